// *** core/rmf_device.sv ***
// Resolver end: frame receive, command decode and input frame return
`timescale 1ns/1ps
module rmf_device
   import rmf_pkg::*;
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        ARST_N,
   // Link
   rmf_link_if.device       LINK,
   // Connection enables
   input  wire logic        POLL_EN,
   input  wire logic        CYCLIC_EN,
   input  wire logic        STROBE_EN,
   input  wire logic [5:0]  STROBE_BIT,
   // Measurement sources
   input  wire logic [31:0] POSITION,
   input  wire logic [31:0] VELOCITY,
   input  wire logic [31:0] SPAN_UNITS,
   input  wire logic [31:0] TOTAL_RANGE,
   input  wire logic [31:0] RAW_POSITION,
   input  wire logic [31:0] TIMESTAMP,
   // Stored state and actions
   output logic [31:0]      PRESET_VALUE,
   output logic [31:0]      POS_OFFSET,
   output logic             PRESET_LOAD,
   output logic             SAVE_REQ,
   output logic [7:0]       COMMAND
);
   typedef struct packed {
      // Receive assembly
      logic [CNT_W-1:0] cnt;
      logic [63:0]      rx;
      // Last accepted output frame and derived offset
      logic [7:0]       cmd;
      logic [31:0]      preset;
      logic [31:0]      offset;
      // Strap copy and one-cycle pulses
      logic [5:0]       sbit;
      logic             load;
      logic             save;
      logic             reply;
   } rmf_dev_s;
   rmf_dev_s st_ff, nxt_st;

   // Reply byte stream from the serialiser flops
   logic             d_valid_w;
   logic [7:0]       d_data_w;
   logic             d_first_w;
   logic [63:0]      reply_frame;
   logic [CNT_W-1:0] rx_last;

   // Second word multiplexer; unlisted codes fall back to velocity
   function automatic logic [31:0] sel_word(
      input logic [7:0] c
   );
      unique case (c)
         CMD_SPAN:   sel_word = SPAN_UNITS;
         CMD_RANGE:  sel_word = TOTAL_RANGE;
         CMD_PRESET: sel_word = st_ff.preset;
         CMD_OFFSET: sel_word = st_ff.offset;
         CMD_TSTAMP: sel_word = TIMESTAMP;
         CMD_RAWPOS: sel_word = RAW_POSITION;
         default:    sel_word = VELOCITY;
      endcase
   endfunction

   // Frame kinds this end listens to under the current enables
   function automatic logic kind_ok(input rmf_conn_e k);
      unique case (k)
         RMF_CONN_POLL:   kind_ok = POLL_EN;
         // Cyclic alongside poll carries no outputs; nothing to take
         RMF_CONN_CYCLIC: kind_ok = CYCLIC_EN && !POLL_EN;
         RMF_CONN_STROBE: kind_ok = STROBE_EN;
         // Any other code would be change of state, never offered
         default:         kind_ok = 1'b0;
      endcase
   endfunction

   // Byte slot of an incoming byte; a first flag restarts the count
   function automatic logic [CNT_W-1:0] slot_of(
      input logic             first_b,
      input logic [CNT_W-1:0] c
   );
      slot_of = first_b ? '0 : c;
   endfunction

   // Two-frame sequences: the arm code must be the previous accepted output frame
   function automatic logic seq_hit(
      input logic [7:0] prev,
      input logic [7:0] cur,
      input logic [7:0] arm,
      input logic [7:0] go
   );
      seq_hit = (prev == arm) && (cur == go);
   endfunction

   // Word pair of the reply, picked by the last command
   assign reply_frame = {sel_word(st_ff.cmd), POSITION};

   // Expected frame length; strobe frames are eight bytes, others five
   always_comb begin
      rx_last = OUT_LAST;
      if (LINK.m_kind == RMF_CONN_STROBE) begin
         rx_last = STB_LAST;
      end
   end

   // Bytes land by slot; the frame end acts on the whole frame
   always_comb begin
      logic [63:0]      full;
      logic [CNT_W-1:0] slot;
      full   = st_ff.rx;
      slot   = slot_of(LINK.m_first, st_ff.cnt);
      nxt_st = st_ff;
      nxt_st.load  = 1'b0;
      nxt_st.save  = 1'b0;
      nxt_st.reply = 1'b0;
      // Strap follows its pin; only a strobe frame end reads it
      nxt_st.sbit  = STROBE_BIT;
      if (LINK.m_valid && kind_ok(LINK.m_kind)) begin
         full[8*slot +: 8] = LINK.m_data;
         nxt_st.rx  = full;
         nxt_st.cnt = slot + 4'h1;
         if (slot == rx_last) begin
            if (LINK.m_kind == RMF_CONN_STROBE) begin
               // Strobe frames never touch command or preset
               nxt_st.reply = full[st_ff.sbit];
            end else begin
               nxt_st.preset = full[31:0];
               nxt_st.cmd    = full[39:32];
               nxt_st.reply  = 1'b1;
               // Offset is taken against the live position
               if (seq_hit(st_ff.cmd, full[39:32],
                           CMD_PRE_ARM, CMD_PRE_GO)) begin
                  nxt_st.offset = full[31:0] - POSITION;
                  nxt_st.load   = 1'b1;
               end
               // Only a request pulse; storage lives outside
               if (seq_hit(st_ff.cmd, full[39:32],
                           CMD_SAVE_ARM, CMD_SAVE_GO)) begin
                  nxt_st.save = 1'b1;
               end
            end
         end
      end
   end

   // Reset clears offset and assembly, leaves velocity selected, zero preset and strap bit 0
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_ff        <= '0;
         st_ff.cmd    <= CMD_RST;
         st_ff.preset <= PRESET_RST;
         st_ff.sbit   <= STB_BIT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // A reply asked for while one is still going out is dropped;
   // the master gates scans only on its own send, so a five-byte scan issued as SCAN_BUSY falls gets no reply
   rmf_serial u_tx (
      .clk    (CORE_CLK),
      .arst_n (ARST_N),
      .start  (st_ff.reply),
      .frame  (reply_frame),
      .last   (IN_LAST),
      .busy   (),
      .valid  (d_valid_w),
      .data   (d_data_w),
      .first  (d_first_w)
   );

   // Link bytes straight from the serialiser flops
   assign LINK.d_valid = d_valid_w;
   assign LINK.d_data  = d_data_w;
   assign LINK.d_first = d_first_w;

   // Stored state and pulses straight from the state flops
   assign PRESET_VALUE = st_ff.preset;
   assign POS_OFFSET   = st_ff.offset;
   assign PRESET_LOAD  = st_ff.load;
   assign SAVE_REQ     = st_ff.save;
   assign COMMAND      = st_ff.cmd;
endmodule

// *** pkg/rmf_pkg.sv ***
// Shared constants and types for the resolver I/O frame link
package rmf_pkg;
   localparam int IN_BYTES      = 8;
   localparam int OUT_BYTES     = 5;
   localparam int STB_BYTES     = 8;
   localparam int CNT_W         = 4;
   localparam logic [CNT_W-1:0] IN_LAST  = 4'h7;
   localparam logic [CNT_W-1:0] OUT_LAST = 4'h4;
   localparam logic [CNT_W-1:0] STB_LAST = 4'h7;
   localparam logic [5:0] STB_BIT_RST = 6'h00;
   // Command byte codes
   localparam logic [7:0] CMD_VEL      = 8'h00;
   localparam logic [7:0] CMD_PRE_ARM  = 8'h02;
   localparam logic [7:0] CMD_PRE_GO   = 8'h0d;
   localparam logic [7:0] CMD_SPAN     = 8'h10;
   localparam logic [7:0] CMD_RANGE    = 8'h11;
   localparam logic [7:0] CMD_PRESET   = 8'h13;
   localparam logic [7:0] CMD_SAVE_ARM = 8'h20;
   localparam logic [7:0] CMD_OFFSET   = 8'h33;
   localparam logic [7:0] CMD_TSTAMP   = 8'h68;
   localparam logic [7:0] CMD_RAWPOS   = 8'h69;
   localparam logic [7:0] CMD_SAVE_GO  = 8'hd0;
   // Connection kinds
   typedef enum logic [1:0] {
      RMF_CONN_POLL   = 2'h0,
      RMF_CONN_CYCLIC = 2'h1,
      RMF_CONN_STROBE = 2'h2
   } rmf_conn_e;
   // Reset values of the stored preset and command
   localparam logic [31:0] PRESET_RST = 32'h0000_0000;
   localparam logic [7:0]  CMD_RST    = 8'h00;
endpackage

// *** pkg/rmf_link_if.sv ***
// Byte stream carrier between scanner end and resolver end
`timescale 1ns/1ps
interface rmf_link_if;
   import rmf_pkg::*;
   // Master to device bytes
   logic       m_valid;
   logic [7:0] m_data;
   logic       m_first;
   rmf_conn_e  m_kind;
   // Device to master bytes
   logic       d_valid;
   logic [7:0] d_data;
   logic       d_first;
   modport master (output m_valid, m_data, m_first, m_kind,
                   input  d_valid, d_data, d_first);
   modport device (input  m_valid, m_data, m_first, m_kind,
                   output d_valid, d_data, d_first);
endinterface

// *** core/rmf_serial.sv ***
// Byte serialiser shared by both ends: sends 5..8 bytes LSB first
`timescale 1ns/1ps
module rmf_serial
   import rmf_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Frame to send
   input  wire logic             start,
   input  wire logic [63:0]      frame,
   input  wire logic [CNT_W-1:0] last,
   // Byte stream
   output logic                  busy,
   output logic                  valid,
   output logic [7:0]            data,
   output logic                  first
);
   typedef struct packed {
      logic             busy;
      logic [CNT_W-1:0] idx;
      logic [CNT_W-1:0] last;
      logic [63:0]      sh;
      logic             valid;
      logic [7:0]       data;
      logic             first;
   } rmf_ser_s;
   rmf_ser_s st_ff, nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.valid = 1'b0;
      nxt_st.first = 1'b0;
      if (!st_ff.busy && start) begin
         nxt_st.busy = 1'b1;
         nxt_st.idx  = '0;
         nxt_st.last = last;
         nxt_st.sh   = frame;
      end else if (st_ff.busy) begin
         nxt_st.valid = 1'b1;
         nxt_st.data  = st_ff.sh[7:0];
         nxt_st.first = (st_ff.idx == '0);
         nxt_st.sh    = {8'h00, st_ff.sh[63:8]};
         nxt_st.idx   = st_ff.idx + 4'h1;
         if (st_ff.idx == st_ff.last) begin
            nxt_st.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Busy from the flop only, so a caller may gate start with it
   assign busy  = st_ff.busy;
   assign valid = st_ff.valid;
   assign data  = st_ff.data;
   assign first = st_ff.first;
endmodule

// *** core/rmf_master.sv ***
// Scanner end: sends output or strobe frames, collects input frames
`timescale 1ns/1ps
module rmf_master
   import rmf_pkg::*;
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        ARST_N,
   // Link
   rmf_link_if.master       LINK,
   // Scan request
   input  wire logic        SCAN_REQ,
   input  wire rmf_conn_e   SCAN_KIND,
   input  wire logic [31:0] SCAN_PRESET,
   input  wire logic [7:0]  SCAN_CMD,
   input  wire logic [63:0] SCAN_STROBE,
   // Scan result
   output logic             SCAN_BUSY,
   output logic             IN_VALID,
   output logic [31:0]      IN_POSITION,
   output logic [31:0]      IN_SECOND
);
   typedef struct packed {
      rmf_conn_e        kind;
      logic [CNT_W-1:0] cnt;
      logic [63:0]      rx;
      logic             in_valid;
      logic [63:0]      result;
   } rmf_mst_s;
   rmf_mst_s st_ff, nxt_st;
   logic        busy_w;
   logic [63:0] tx_frame;
   logic [CNT_W-1:0] tx_last;

   always_comb begin
      tx_frame = {24'h00_0000, SCAN_CMD, SCAN_PRESET};
      tx_last  = OUT_LAST;
      if (SCAN_KIND == RMF_CONN_STROBE) begin
         tx_frame = SCAN_STROBE;
         tx_last  = STB_LAST;
      end
   end

   always_comb begin
      logic [63:0] full;
      full = st_ff.rx;
      nxt_st = st_ff;
      nxt_st.in_valid = 1'b0;
      if (SCAN_REQ && !busy_w) begin
         nxt_st.kind = SCAN_KIND;
      end
      if (LINK.d_valid) begin
         full[8*(LINK.d_first ? 4'h0 : st_ff.cnt) +: 8] = LINK.d_data;
         nxt_st.rx  = full;
         nxt_st.cnt = (LINK.d_first ? 4'h0 : st_ff.cnt) + 4'h1;
         if ((LINK.d_first ? 4'h0 : st_ff.cnt) == IN_LAST) begin
            nxt_st.in_valid = 1'b1;
            nxt_st.result   = full;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   rmf_serial u_tx (
      .clk    (CORE_CLK),
      .arst_n (ARST_N),
      .start  (SCAN_REQ && !busy_w),
      .frame  (tx_frame),
      .last   (tx_last),
      .busy   (busy_w),
      .valid  (LINK.m_valid),
      .data   (LINK.m_data),
      .first  (LINK.m_first)
   );

   assign LINK.m_kind = st_ff.kind;
   assign SCAN_BUSY   = busy_w;
   assign IN_VALID    = st_ff.in_valid;
   assign IN_POSITION = st_ff.result[31:0];
   assign IN_SECOND   = st_ff.result[63:32];
endmodule

// *** dv/rmf_link_sva.sv ***
// Link protocol assertions for the resolver frame link
`timescale 1ns/1ps
module rmf_link_sva
   import rmf_pkg::*;
(
   // Clock and reset
   input wire logic       CORE_CLK,
   input wire logic       ARST_N,
   // Master to device
   input wire logic       m_valid,
   input wire logic [7:0] m_data,
   input wire logic       m_first,
   input wire rmf_conn_e  m_kind,
   // Device to master
   input wire logic       d_valid,
   input wire logic [7:0] d_data,
   input wire logic       d_first
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);
   sequence s_in_frame;
      d_valid [*8] ##1 !d_valid;
   endsequence
   sequence s_out_frame;
      m_valid [*5] ##1 !m_valid;
   endsequence
   sequence s_stb_frame;
      m_valid [*8] ##1 !m_valid;
   endsequence
   chk_in_length: assert property (d_first |-> s_in_frame)
      else $error("input frame length wrong");
   chk_out_length: assert property
      (m_first && m_kind != RMF_CONN_STROBE |-> s_out_frame)
      else $error("output frame length wrong");
   chk_strobe_length: assert property
      (m_first && m_kind == RMF_CONN_STROBE |-> s_stb_frame)
      else $error("strobe frame length wrong");
   chk_kind_held: assert property
      (m_valid && !m_first |-> $stable(m_kind))
      else $error("kind changed inside a frame");
   chk_reply_delay: assert property
      (d_first |-> $past(m_valid, 3) && !$past(m_valid, 2) &&
                   !$past(m_valid))
      else $error("reply not three cycles after last byte");
   chk_single_first: assert property (d_first |=> !d_first [*7])
      else $error("reply restarted early");
   chk_in_contig: assert property
      (d_valid && !d_first |-> $past(d_valid))
      else $error("input byte without frame start");
   chk_no_cos: assert property
      (m_valid |-> m_kind inside {RMF_CONN_POLL, RMF_CONN_CYCLIC,
                                  RMF_CONN_STROBE})
      else $error("unsupported connection kind");
   chk_out_start: assert property
      (m_first |-> m_valid && !$past(m_valid))
      else $error("output frames overlap");
endmodule

// *** dv/resolver_io_message_frames_bench.sv ***
// Self-checking bench joining scanner and resolver ends
`timescale 1ns/1ps
module resolver_io_message_frames_bench;
   import rmf_pkg::*;
   logic        clk = 1'b0, arst_n = 1'b0, req = 1'b0;
   logic        pen = 1'b1, cen = 1'b0, sen = 1'b0;
   rmf_conn_e   kind = RMF_CONN_POLL;
   logic [5:0]  sbit = 6'h00;
   logic [31:0] pre = 32'h0, meas [6] = '{default: 32'h0};
   logic [7:0]  cmd = 8'h00, cmd_q, last_cmd = 8'h00;
   logic [63:0] strobe = 64'h0, dbuf, mbuf;
   logic        inv, pload, sreq, sbusy;
   logic [31:0] in_pos, in_sec, pre_q, off_q;
   logic [31:0] seed = 32'd88464, off_exp = 32'h0, last_pre = 32'h0;
   logic [7:0]  cmds [9] = '{8'h00, 8'h10, 8'h11, 8'h13, 8'h33, 8'h68,
                             8'h69, 8'h5a, 8'hff};
   int          n_errors = 0, check_count = 0, nrep = 0, npl = 0, nsv = 0;
   int          epl = 0, esv = 0;
   always #2.5 clk = ~clk;
   rmf_link_if link ();
   rmf_master i_rmf_master (.CORE_CLK(clk), .ARST_N(arst_n), .LINK(link),
      .SCAN_REQ(req), .SCAN_KIND(kind), .SCAN_PRESET(pre), .SCAN_CMD(cmd),
      .SCAN_STROBE(strobe), .SCAN_BUSY(sbusy), .IN_VALID(inv),
      .IN_POSITION(in_pos), .IN_SECOND(in_sec));
   rmf_device i_rmf_device (.CORE_CLK(clk), .ARST_N(arst_n), .LINK(link),
      .POLL_EN(pen), .CYCLIC_EN(cen), .STROBE_EN(sen), .STROBE_BIT(sbit),
      .POSITION(meas[0]), .VELOCITY(meas[1]), .SPAN_UNITS(meas[2]),
      .TOTAL_RANGE(meas[3]), .RAW_POSITION(meas[4]), .TIMESTAMP(meas[5]),
      .PRESET_VALUE(pre_q), .POS_OFFSET(off_q), .PRESET_LOAD(pload),
      .SAVE_REQ(sreq), .COMMAND(cmd_q));
   rmf_link_sva i_rmf_link_sva (.CORE_CLK(clk), .ARST_N(arst_n),
      .m_valid(link.m_valid), .m_data(link.m_data), .m_first(link.m_first),
      .m_kind(link.m_kind), .d_valid(link.d_valid), .d_data(link.d_data),
      .d_first(link.d_first));
   // Bytes shift in from the top, so LSB-first words land in place
   always @(posedge clk) begin
      if (link.d_valid) dbuf <= {link.d_data, dbuf[63:8]};
      if (link.m_valid) mbuf <= {link.m_data, mbuf[63:8]};
      if (link.d_first) nrep <= nrep + 1;
      if (pload) npl <= npl + 1;
      if (sreq) nsv <= nsv + 1;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] exp2(logic [7:0] c);
      case (c)
         CMD_SPAN:   return meas[2];
         CMD_RANGE:  return meas[3];
         CMD_PRESET: return last_pre;
         CMD_OFFSET: return off_exp;
         CMD_TSTAMP: return meas[5];
         CMD_RAWPOS: return meas[4];
         default:    return meas[1];
      endcase
   endfunction
   task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Entered and left just after a rising edge
   task automatic scan(rmf_conn_e k, logic [7:0] c, logic [63:0] sb,
                       bit rep);
      int i;
      int n0;
      logic [31:0] p;
      p = rnd();
      n0 = nrep;
      for (i = 0; i < 6; i++) meas[i] = rnd();
      kind = k;
      cmd = c;
      pre = p;
      strobe = sb;
      req = 1'b1;
      @(posedge clk);
      #1 req = 1'b0;
      chk("scan busy", sbusy, 1'b1);
      for (i = 0; i < 30; i++) begin
         @(posedge clk);
         #1;
         if (inv === 1'b1) break;
      end
      if (rep && i == 30) begin
         n_errors++;
         $display("unexpected timeout: expected reply seen none");
         summarize();
      end
      // Strobe and refused frames leave command and preset alone
      if (k != RMF_CONN_STROBE && rep) begin
         if (last_cmd == CMD_PRE_ARM && c == CMD_PRE_GO) begin
            epl++;
            off_exp = p - meas[0];
         end
         if (last_cmd == CMD_SAVE_ARM && c == CMD_SAVE_GO) esv++;
         last_cmd = c;
         last_pre = p;
      end
      chk("scan idle", sbusy, 1'b0);
      chk("reply count", nrep, n0 + rep);
      if (k == RMF_CONN_STROBE) chk("strobe frame", mbuf, sb);
      else chk("output frame", mbuf[63:24], {c, p});
      if (rep) begin
         chk("position", in_pos, meas[0]);
         chk("second word", in_sec, exp2(last_cmd));
         chk("input frame", dbuf, {exp2(last_cmd), meas[0]});
      end
      chk("command", cmd_q, last_cmd);
      chk("preset", pre_q, last_pre);
      chk("load count", npl, epl);
      chk("offset", off_q, off_exp);
      chk("save count", nsv, esv);
   endtask
   task automatic seq(logic [7:0] a, logic [7:0] b, logic [7:0] c);
      scan(RMF_CONN_POLL, a, 64'h0, 1'b1);
      scan(RMF_CONN_POLL, b, 64'h0, 1'b1);
      scan(RMF_CONN_POLL, c, 64'h0, 1'b1);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 arst_n = 1'b1;
      chk("command at reset", cmd_q, 8'h00);
      chk("preset at reset", pre_q, 32'h0);
      scan(RMF_CONN_STROBE, 8'h00, 64'hffff_ffff_ffff_ffff, 1'b0);
      foreach (cmds[j]) scan(RMF_CONN_POLL, cmds[j], 64'h0, 1'b1);
      $display("test defaults and command table done");
      seq(CMD_PRE_ARM, CMD_PRE_GO, CMD_OFFSET);
      seq(CMD_PRE_ARM, CMD_SPAN, CMD_PRE_GO);
      seq(CMD_SAVE_ARM, CMD_SAVE_GO, CMD_PRE_ARM);
      seq(CMD_SAVE_ARM, CMD_VEL, CMD_SAVE_GO);
      $display("test preset and save sequences done");
      sen = 1'b1;
      sbit = 6'(rnd());
      scan(RMF_CONN_STROBE, 8'h00, 64'h1 << sbit, 1'b1);
      scan(RMF_CONN_STROBE, 8'h00, ~(64'h1 << sbit), 1'b0);
      $display("test strobe done");
      scan(RMF_CONN_CYCLIC, CMD_SPAN, 64'h0, 1'b0);
      pen = 1'b0;
      cen = 1'b1;
      scan(RMF_CONN_CYCLIC, CMD_RANGE, 64'h0, 1'b1);
      scan(RMF_CONN_POLL, CMD_SPAN, 64'h0, 1'b0);
      pen = 1'b1;
      $display("test connection kinds done");
      repeat (40) scan(RMF_CONN_POLL, cmds[rnd() % 9], 64'h0, 1'b1);
      $display("test random polls done");
      summarize();
   end
endmodule
